// *** rtl/encfb_consts.vh ***
// constants for the encoder feedback setup block
`ifndef ENCFB_CONSTS_VH
`define ENCFB_CONSTS_VH
// encoder type codes
`define ENCFB_T_QUAD_NC 4'h0
`define ENCFB_T_PD_NC 4'h1
`define ENCFB_T_FWREV_NC 4'h2
`define ENCFB_T_QUAD_WC 4'h3
`define ENCFB_T_PD_WC 4'h4
`define ENCFB_T_FWREV_WC 4'h5
`define ENCFB_T_SINC_PLAIN 4'h6
`define ENCFB_T_SINC_PA 4'h7
`define ENCFB_T_SER_ABS 4'h8
`define ENCFB_T_SINC_PB 4'h9
`define ENCFB_T_SINC_SYNC 4'ha
// family codes
`define ENCFB_F_QUAD 3'h0
`define ENCFB_F_PD 3'h1
`define ENCFB_F_FWREV 3'h2
`define ENCFB_F_SINC 3'h3
`define ENCFB_F_SER 3'h4
`define ENCFB_F_BAD 3'h7
// supply codes
`define ENCFB_SUP_5V 2'h0
`define ENCFB_SUP_8V 2'h1
`define ENCFB_SUP_15V 2'h2
// register offsets
`define ENCFB_A_TYPE 4'h0
`define ENCFB_A_SUPPLY 4'h1
`define ENCFB_A_LINES 4'h2
`define ENCFB_A_TERM 4'h3
`define ENCFB_A_ERRLVL 4'h4
`define ENCFB_A_AUTOFMT 4'h5
`define ENCFB_A_BAUD 4'h6
`define ENCFB_A_TURNS 4'h7
`define ENCFB_A_RES 4'h8
`define ENCFB_A_STATUS 4'h9
`define ENCFB_A_MASK 4'ha
`define ENCFB_A_DECODE 4'hb
// status bit positions
`define ENCFB_S_WIRE 0
`define ENCFB_S_PHASE 1
`define ENCFB_S_AUTO 2
// reset values
`define ENCFB_RST_LINES 16'h0400
`define ENCFB_RST_BAUD 16'h012c
`define ENCFB_RST_TURNS 5'h10
`define ENCFB_RST_RES 5'h11
`endif

// *** rtl/encfb_setup.v ***
// encoder feedback setup: type decode, termination, error checks, fault status
// Overview of operation
// R1: type 0,3,6 quadrature plain, quadrature commutated, sincos
// R2: type 1,4 pulse-direction without/with commutation
// R3: type 2,5 forward/reverse without/with commutation
// R4: software sets lines to encoder lines
// R5: software sets lines to half pulses
// R6: quad termination 0 none, 1 count, 2 all
// R7: pulse types use same termination codes
// R8: quad error level off, wire, phase, both
// R9: quad phase check only with commutation
// R10: pulse phase check only commutated; wire covers three
// R11: wire break needs termination enabled
// R12: supply select 0 5V, 1 8V, 2 15V
// R13: software disables termination above 5V quadrature
// R14: auto-config fills turns, lines, resolution; the code leaves lines as written for the serial absolute type
// R15: shared bit: auto-config enable or binary format
// R16: baud only used by serial types
// R17: failed enabled check latches readable clearable fault
// R18: type 7,8,9 sincos-a, serial absolute, sincos-b
`timescale 1ns/100ps
`include "encfb_consts.vh"

module encfb_setup #(
  parameter LINES_W = 16
) (
  input wire clk,
  input wire arst_n,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire line_a_lost,
  input wire line_b_lost,
  input wire line_z_lost,
  input wire phase_err_in,
  input wire auto_valid,
  input wire [4:0] auto_turns,
  input wire [LINES_W-1:0] auto_lines,
  input wire [4:0] auto_res,
  output reg term_ab_en,
  output reg term_z_en,
  output reg [1:0] supply_sel,
  output reg comm_lines_used,
  output reg serial_used,
  output reg gray_format,
  output wire irq
);

  // ****************************************
  // type decoding
  // ****************************************

  // the type code picks one of five families and says whether
  // commutation lines or a serial channel come with it
  // the decode is shared by the checks, the pin controls and the readback

  // family of a type code; unknown codes decode as bad so no check or termination applies
  function [2:0] fam_of;
    input [3:0] t;
    begin
      case (t)
        `ENCFB_T_QUAD_NC, `ENCFB_T_QUAD_WC: fam_of = `ENCFB_F_QUAD; // [R1]
        `ENCFB_T_PD_NC, `ENCFB_T_PD_WC: fam_of = `ENCFB_F_PD; // [R2]
        `ENCFB_T_FWREV_NC, `ENCFB_T_FWREV_WC: fam_of = `ENCFB_F_FWREV; // [R3]
        `ENCFB_T_SINC_PLAIN: fam_of = `ENCFB_F_SINC; // [R1]
        `ENCFB_T_SINC_PA, `ENCFB_T_SINC_PB, `ENCFB_T_SINC_SYNC: fam_of = `ENCFB_F_SINC; // [R18]
        `ENCFB_T_SER_ABS: fam_of = `ENCFB_F_SER; // [R18]
        default: fam_of = `ENCFB_F_BAD;
      endcase
    end
  endfunction

  // commutated variants carry extra motor position lines
  function is_comm;
    input [3:0] t;
    begin
      is_comm = (t == `ENCFB_T_QUAD_WC) || (t == `ENCFB_T_PD_WC) || (t == `ENCFB_T_FWREV_WC); // [R1] [R2] [R3]
    end
  endfunction

  // types with a serial channel
  function is_serial;
    input [3:0] t;
    begin
      is_serial = (t == `ENCFB_T_SINC_PA) || (t == `ENCFB_T_SER_ABS) || (t == `ENCFB_T_SINC_PB) ||
                  (t == `ENCFB_T_SINC_SYNC); // [R18]
    end
  endfunction

  // codes 0 to 2 kept as written
  // the spare code 3 folds onto 2 so a stray write never leaves an unknown setting
  function [1:0] sat2;
    input [1:0] c;
    begin
      sat2 = (c == 2'h3) ? 2'h2 : c;
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************

  // number of fault pins and of status events
  localparam N_PINS = 4;
  localparam N_EV = 3;

  // reset leaves a quadrature encoder on the lowest supply with count termination on
  // limitation: settings act at once, so change type and checks while the axis is idle
  // lines, turns and resolution may also be refilled by auto-config
  reg [3:0] type_r;
  reg [1:0] supply_r;
  reg [LINES_W-1:0] lines_r;
  reg [1:0] term_r;
  reg [1:0] errlvl_r;
  reg autofmt_r;
  reg [15:0] baud_r;
  reg [4:0] turns_r;
  reg [4:0] res_r;
  reg [2:0] mask_r;
  reg [15:0] rdata_nxt;

  // decoded type and derived controls
  wire [2:0] fam;
  wire type_comm;
  wire type_serial;
  wire type_sync;
  wire incr;
  wire term_ab_nxt;
  wire term_z_nxt;
  wire gray_nxt;
  wire [LINES_W+15:0] lines_ext;

  // fault path
  wire [3:0] pin_raw;
  wire [3:0] lost;
  wire [2:0] ev;
  wire [2:0] status;
  wire wire_chk;
  wire phase_chk;
  wire wr_status;

  assign fam = fam_of(type_r);
  assign type_comm = is_comm(type_r);
  assign type_serial = is_serial(type_r);
  assign type_sync = (type_r == `ENCFB_T_SINC_SYNC);
  // incremental families use termination and wire checks
  assign incr = (fam == `ENCFB_F_QUAD) || (fam == `ENCFB_F_PD) || (fam == `ENCFB_F_FWREV);
  // zero-extended copy so the readback works for any line width up to 16
  assign lines_ext = {16'h0000, lines_r};

  // wire checks only meaningful with termination on, since the sense runs through the resistors
  assign wire_chk = incr && errlvl_r[0] && (term_r != 2'h0); // [R8] [R10] [R11]
  // phase checks only on commutated variants
  assign phase_chk = incr && errlvl_r[1] && type_comm; // [R8] [R9] [R10]

  // z line only counts when its termination is on
  assign ev[`ENCFB_S_WIRE] = wire_chk && (lost[0] || lost[1] || (lost[2] && term_r == 2'h2)); // [R10] [R17]
  // phase error is an outside flag; this block only gates and latches it
  assign ev[`ENCFB_S_PHASE] = phase_chk && lost[3]; // [R17]
  // the sync-serial type reads the shared bit as format, so it never auto-configures
  assign ev[`ENCFB_S_AUTO] = auto_valid && autofmt_r && !type_sync && type_serial; // [R14] [R15]
  // status write strobe, used by the sticky bits
  assign wr_status = reg_wr && (reg_addr == `ENCFB_A_STATUS);

  // ****************************************
  // pin synchronisers
  // ****************************************

  // the fault pins come from the motor cable and are not timed to clk
  // each passes its own chain, so the pins may settle in different cycles

  // fault pins in bit order a, b, z, phase
  assign pin_raw = {phase_err_in, line_z_lost, line_b_lost, line_a_lost};

  // three stages; a level is taken once stages two and three agree, which drops one-cycle glitches
  // stage one is read only by stage two
  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi = gi + 1) begin : g_sync
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg take_r;
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          take_r <= 1'b0;
        end else begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            take_r <= s3_r;
          end
        end
      end
      assign lost[gi] = take_r;
    end
  endgenerate

  // ****************************************
  // register writes
  // ****************************************

  // writes land at the edge that takes the strobe
  // unmapped indices and the read-only decode word ignore writes

  // plain settings written by software only
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      type_r <= `ENCFB_T_QUAD_NC;
      supply_r <= `ENCFB_SUP_5V;
      term_r <= 2'h1;
      errlvl_r <= 2'h0;
      autofmt_r <= 1'b0;
      baud_r <= `ENCFB_RST_BAUD;
      mask_r <= 3'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ENCFB_A_TYPE: type_r <= reg_wdata[3:0]; // [R1] [R2] [R3] [R18]
        `ENCFB_A_SUPPLY: supply_r <= sat2(reg_wdata[1:0]); // [R12]
        `ENCFB_A_TERM: term_r <= sat2(reg_wdata[1:0]); // [R6] [R7]
        `ENCFB_A_ERRLVL: errlvl_r <= reg_wdata[1:0]; // [R8]
        `ENCFB_A_AUTOFMT: autofmt_r <= reg_wdata[0]; // [R15]
        `ENCFB_A_BAUD: baud_r <= reg_wdata; // [R16]
        `ENCFB_A_MASK: mask_r <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // serial parameters: software writes them, and a same-cycle auto-config update wins
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lines_r <= `ENCFB_RST_LINES;
      turns_r <= `ENCFB_RST_TURNS;
      res_r <= `ENCFB_RST_RES;
    end else begin
      if (reg_wr && (reg_addr == `ENCFB_A_LINES)) begin
        lines_r <= reg_wdata[LINES_W-1:0]; // [R4] [R5]
      end
      if (reg_wr && (reg_addr == `ENCFB_A_TURNS)) begin
        turns_r <= reg_wdata[4:0];
      end
      if (reg_wr && (reg_addr == `ENCFB_A_RES)) begin
        res_r <= reg_wdata[4:0];
      end
      // limitation: a software value written in the same cycle as an update is lost
      if (ev[`ENCFB_S_AUTO]) begin
        turns_r <= auto_turns; // [R14]
        res_r <= auto_res; // [R14]
        // a serial-only encoder has no sine cycles, so its line count stays as written
        if (type_r != `ENCFB_T_SER_ABS) begin
          lines_r <= auto_lines; // [R14]
        end
      end
    end
  end

  // ****************************************
  // fault status and interrupt
  // ****************************************

  // the events are levels while a fault stands, so a bit cannot be cleared
  // until its cause has gone; auto-config done is a single-cycle event
  // bit 0 wire break, bit 1 phase error, bit 2 auto-config done

  // one sticky bit per event, write one to clear; a new event wins over a clear in the same cycle
  generate
    for (gi = 0; gi < N_EV; gi = gi + 1) begin : g_sticky
      reg flag_r;
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          flag_r <= 1'b0;
        end else begin
          flag_r <= (flag_r && !(wr_status && reg_wdata[gi])) || ev[gi]; // [R17]
        end
      end
      assign status[gi] = flag_r;
    end
  endgenerate

  // level output: it drops only when software clears the bit or masks it
  // combinational from two registers, so it carries no glitch
  assign irq = |(status & mask_r); // [R17]

  // ****************************************
  // pin controls and readback
  // ****************************************

  // all pin controls are registered, one edge behind the settings
  // read data stands one cycle after the strobe and is zero otherwise

  // termination only for incremental types; codes shared across families
  assign term_ab_nxt = incr && (term_r != 2'h0); // [R6] [R7]
  assign term_z_nxt = incr && (term_r == 2'h2); // [R6] [R7]
  // ssi uses the shared bit as format: 0 gray, 1 binary
  assign gray_nxt = type_sync && !autofmt_r; // [R15]

  // read mux; unmapped indices read as zero
  always @* begin
    rdata_nxt = 16'h0000;
    case (reg_addr)
      `ENCFB_A_TYPE: rdata_nxt = {12'h000, type_r};
      `ENCFB_A_SUPPLY: rdata_nxt = {14'h0000, supply_r};
      `ENCFB_A_LINES: rdata_nxt = lines_ext[15:0];
      `ENCFB_A_TERM: rdata_nxt = {14'h0000, term_r};
      `ENCFB_A_ERRLVL: rdata_nxt = {14'h0000, errlvl_r};
      `ENCFB_A_AUTOFMT: rdata_nxt = {15'h0000, autofmt_r};
      `ENCFB_A_BAUD: rdata_nxt = baud_r;
      `ENCFB_A_TURNS: rdata_nxt = {11'h000, turns_r};
      `ENCFB_A_RES: rdata_nxt = {11'h000, res_r};
      `ENCFB_A_STATUS: rdata_nxt = {13'h0000, status};
      `ENCFB_A_MASK: rdata_nxt = {13'h0000, mask_r};
      // decode word: serial, commutation, family
      `ENCFB_A_DECODE: rdata_nxt = {11'h000, serial_used, comm_lines_used, fam};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // reset leaves every pin control off, with the supply select on 5V
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      term_ab_en <= 1'b0;
      term_z_en <= 1'b0;
      supply_sel <= `ENCFB_SUP_5V;
      comm_lines_used <= 1'b0;
      serial_used <= 1'b0;
      gray_format <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      term_ab_en <= term_ab_nxt; // [R6] [R7]
      term_z_en <= term_z_nxt; // [R6] [R7]
      supply_sel <= supply_r; // [R12]
      comm_lines_used <= type_comm; // [R1] [R2] [R3]
      serial_used <= type_serial; // [R16]
      gray_format <= gray_nxt; // [R15]
      reg_rdata <= reg_rd ? rdata_nxt : 16'h0000;
    end
  end

endmodule // encfb_setup

// *** test/encfb_setup_checker.sv ***
// assertion checker for the encoder feedback setup block
`timescale 1ns/100ps
module encfb_chk (
  input wire clk, arst_n, reg_wr, reg_rd, term_ab_en, term_z_en, comm_lines_used, serial_used, gray_format,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata, reg_rdata,
  input wire [1:0] supply_sel
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_sup_wr; reg_wr && reg_addr == 4'h1 && reg_wdata < 16'h3 ##1 !(reg_wr && reg_addr == 4'h1); endsequence
  sequence s_type_wr; reg_wr && reg_addr == 4'h0 ##1 !(reg_wr && reg_addr == 4'h0); endsequence
  a_supply_follow: assert property (s_sup_wr |=> supply_sel == $past(reg_wdata[1:0], 2))
    else $error("supply select wrong");
  a_supply_code: assert property (supply_sel != 2'h3)
    else $error("supply code out of range");
  a_comm_decode: assert property (s_type_wr |=>
    comm_lines_used == ($past(reg_wdata[3:0], 2) inside {[4'h3:4'h5]}))
    else $error("commutation flag wrong");
  a_serial_decode: assert property (s_type_wr |=>
    serial_used == ($past(reg_wdata[3:0], 2) inside {[4'h7:4'ha]}))
    else $error("serial flag wrong");
  a_term_off: assert property (reg_wr && reg_addr == 4'h3 && reg_wdata == 16'h0 |=> ##1 !term_ab_en && !term_z_en)
    else $error("termination not off");
  a_z_needs_ab: assert property (term_z_en |-> term_ab_en)
    else $error("index termination alone");
  a_gray_serial: assert property (gray_format |-> serial_used)
    else $error("gray format outside serial type");
  a_read_idle: assert property (!reg_rd |=> reg_rdata == 16'h0)
    else $error("read data outside read slot");
endmodule // encfb_chk

bind encfb_setup encfb_chk u_chk (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .term_ab_en(term_ab_en), .term_z_en(term_z_en), .comm_lines_used(comm_lines_used), .serial_used(serial_used),
  .gray_format(gray_format), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .supply_sel(supply_sel));

// *** test/encfb_enc_model.sv ***
// behavioural motor encoder: line faults, phase fault, serial parameters
`timescale 1ns/100ps
module encfb_enc_model (
  input wire clk, arst_n, push,
  input wire [3:0] fault,
  input wire [25:0] pos_info,
  output reg line_a_lost, line_b_lost, line_z_lost, phase_err_in, auto_valid,
  output reg [25:0] auto_word
);
  // serial word only valid with the strobe; scrambled otherwise to expose stale use
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {phase_err_in, line_z_lost, line_b_lost, line_a_lost, auto_valid} <= 5'h0;
      auto_word <= 26'h0;
    end else begin
      {phase_err_in, line_z_lost, line_b_lost, line_a_lost} <= fault;
      auto_valid <= push;
      auto_word <= push ? pos_info : ~auto_word;
    end
  end
endmodule // encfb_enc_model

// *** test/tb.sv ***
// self-checking testbench for the encoder feedback setup block
`timescale 1ns/100ps
module tb;
  localparam logic [15:0] RV [16] = '{2: 16'h400, 3: 16'h1, 6: 16'h12c, 7: 16'h10, 8: 16'h11, default: 16'h0};
  reg clk, arst_n, wr_s, rd_s, push;
  reg [3:0] ad, fault;
  reg [15:0] wd, v;
  reg [31:0] pi;
  reg [2:0] m;
  wire [25:0] aw;
  wire [15:0] rdat;
  wire [1:0] sup;
  wire la, lb, lz, ph, av, tab, tz, comm, ser, gray, irq;
  integer error_cnt, n_compared, cyc, i;
  encfb_setup DUT (.clk(clk), .arst_n(arst_n), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_rdata(rdat), .line_a_lost(la), .line_b_lost(lb), .line_z_lost(lz), .phase_err_in(ph), .auto_valid(av),
    .auto_turns(aw[25:21]), .auto_lines(aw[20:5]), .auto_res(aw[4:0]), .term_ab_en(tab), .term_z_en(tz),
    .supply_sel(sup), .comm_lines_used(comm), .serial_used(ser), .gray_format(gray), .irq(irq));
  encfb_enc_model u_enc (.clk(clk), .arst_n(arst_n), .push(push), .fault(fault), .pos_info(pi[25:0]),
    .line_a_lost(la), .line_b_lost(lb), .line_z_lost(lz), .phase_err_in(ph), .auto_valid(av), .auto_word(aw));
  // ****
  // clock, hang guard, bus tasks
  // ****
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // the sequence needs about 430 cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // strobes drop a cycle early so two calls never drive one signal twice at an edge
  task wr(input [3:0] a, input [15:0] d);
    begin
      ad <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [3:0] a, input [15:0] e);
    begin
      ad <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk($sformatf("reg %h", a), e, rdat);
      @(posedge clk);
    end
  endtask
  function [15:0] dec(input [3:0] t);
    begin
      dec = {11'h0, t > 4'h6 && t < 4'hb, t > 4'h2 && t < 4'h6, 3'h0};
      dec[2:0] = t > 4'ha ? 3'h7 : t == 4'h8 ? 3'h4 : t > 4'h5 ? 3'h3 : 3'(t % 4'h3);
    end
  endfunction
  // fault held, cleared while held (set must win), then released and cleared
  task flt(input [3:0] t, input [3:0] tm, input [3:0] lv, input [3:0] f, input [2:0] e);
    begin
      wr(4'h0, {12'h0, t});
      wr(4'h3, {12'h0, tm});
      wr(4'h4, {12'h0, lv});
      wr(4'h9, 16'h7);
      fault <= f;
      repeat (6) @(posedge clk);
      wr(4'h9, 16'h7);
      rd(4'h9, {13'h0, e});
      chk("irq", {15'h0, |(e & m)}, {15'h0, irq});
      fault <= 4'h0;
      repeat (6) @(posedge clk);
      wr(4'h9, 16'h7);
      rd(4'h9, 16'h0);
    end
  endtask
  task auto(input [3:0] t, input f, input ln, input up);
    begin
      v = 16'($urandom);
      wr(4'h0, {12'h0, t});
      wr(4'h5, {15'h0, f});
      wr(4'h2, v);
      wr(4'h9, 16'h7);
      pi <= $urandom;
      push <= 1'b1;
      @(posedge clk);
      push <= 1'b0;
      repeat (2) @(posedge clk);
      rd(4'h2, ln ? pi[20:5] : v);
      rd(4'h9, {13'h0, up, 2'h0});
      if (up) begin
        rd(4'h7, {11'h0, pi[25:21]});
        rd(4'h8, {11'h0, pi[4:0]});
      end
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    {arst_n, wr_s, rd_s, push, ad, fault, wd, pi, m} = 0;
    {error_cnt, n_compared, cyc} = 0;
    v = 16'($urandom(32'h9459));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 16; i = i + 1)
      rd(i[3:0], RV[i]);
    chk("term", 16'h2, {14'h0, tab, tz});
    wr(4'hc, 16'hffff);
    wr(4'hb, 16'hffff);
    rd(4'hb, 16'h0);
    for (i = 0; i < 16; i = i + 1) begin
      wr(4'h0, i[15:0]);
      v = dec(i[3:0]);
      rd(4'hb, v);
      chk("flags", {13'h0, v[4:3], i == 10}, {13'h0, ser, comm, gray});
    end
    // pulse type kept so raised supply never meets quadrature termination
    wr(4'h0, 16'h4);
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'h1, i[15:0]);
      wr(4'h3, i[15:0]);
      rd(4'h3, i == 3 ? 16'h2 : i[15:0]);
      chk("outs", {12'h0, i != 0, i > 1, i == 3 ? 2'h2 : i[1:0]}, {12'h0, tab, tz, sup});
    end
    wr(4'h1, 16'h0);
    m = 3'h7;
    wr(4'ha, 16'h7);
    flt(4'h0, 4'h1, 4'h1, 4'h1 << ($urandom % 2), 3'h1);
    flt(4'h0, 4'h1, 4'h1, 4'h4, 3'h0);
    flt(4'h4, 4'h2, 4'h1, 4'h4, 3'h1);
    flt(4'h1, 4'h0, 4'h1, 4'h1, 3'h0);
    flt(4'h0, 4'h1, 4'h2, 4'h8, 3'h0);
    flt(4'h3, 4'h1, 4'h3, 4'h8, 3'h2);
    flt(4'h5, 4'h0, 4'h3, 4'h9, 3'h2);
    m = 3'h0;
    wr(4'ha, 16'h0);
    flt(4'h2, 4'h1, 4'h1, 4'h2, 3'h1);
    auto(4'h8, 1'b1, 1'b0, 1'b1);
    auto(4'h7, 1'b1, 1'b1, 1'b1);
    auto(4'h9, 1'b0, 1'b0, 1'b0);
    auto(4'ha, 1'b1, 1'b0, 1'b0);
    chk("gray", 16'h0, {15'h0, gray});
    test_done;
  end
endmodule // tb
